// ===== src/rcw_consts.svh
// Constants for the hard-reset configuration word latch
// How it works
// - The 32-bit configuration word is captured from the internal data bus, bits 0 to 31, when hard reset is released.
// - With the source select low the internal bus mirrors the external bus, which the outside party drives during the release.
// - With the internal source selected and flash words disabled the internal bus is driven with all zeros for the capture.
// - The captured word has no address of its own; its bits only set reset values of system interface register fields.
// - Word bit 0 picks bus arbitration: 0 internal arbiter, 1 external arbiter.
// - Word bit 1 becomes the processor interrupt-prefix bit right after reset, default zero.
// - Word bit 2 sets bus and clock-out drive, 0 full and 1 reduced, and the default clock-out mode.
// - Word bit 3 at 0 makes bank 0 active and matching every address on the boot chip select; at 1 it stays inactive.
// - Once software writes the bank 0 option register the boot setting is ignored and bank 0 follows that register.
`ifndef RCW_CONSTS_SVH
`define RCW_CONSTS_SVH

// Word bits in big-endian numbering, bit 0 is the MSB of the bus
`define CFG_ARB_BIT    0
`define CFG_PREFIX_BIT 1
`define CFG_DRIVE_BIT  2
`define CFG_BOOT_BIT   3

// Register word indices on wb_adr_i[7:2]
`define REG_SYSCFG_IDX 6'h00
`define REG_BANK0_IDX  6'h01
`define REG_STATUS_IDX 6'h02

// Field positions in the system interface config register
`define SYSCFG_ARB_POS    0
`define SYSCFG_DRIVE_POS  1
`define SYSCFG_CLOCK_OUTPUT_PIN_LSB 2

`define CLOCK_OUTPUT_PIN_MODE_FULL    2'h0
`define CLOCK_OUTPUT_PIN_MODE_REDUCED 2'h1
`define BANK0_OPT_RST       32'h00000000
`define SYNC_W              34

`endif

// ===== src/rcw_pkg.sv
// Types for the hard-reset configuration word latch
`include "rcw_consts.svh"

package rcw_pkg;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } phase_t;

  typedef struct packed {
    logic [1:0] clock_output_pin_mode;
    logic       bus_drive_reduce;
    logic       external_arbitration_sel;
  } sys_cfg_t;

  typedef struct packed {
    phase_t      phase;
    logic        hr_prev;
    logic [31:0] word;
    logic        interrupt_prefix;
    sys_cfg_t    syscfg;
    logic [31:0] bank0_opt;
    logic        bank0_written;
    logic        ack;
    logic [31:0] dat;
  } latch_state_t;

  typedef struct packed {
    logic [`SYNC_W-1:0] meta;
    logic [`SYNC_W-1:0] sync;
  } sync_state_t;

endpackage

// ===== src/pin_sync.sv
// Two-stage synchroniser for the reset-time pins
`timescale 1ns/1ns
`include "rcw_consts.svh"

module pin_sync (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Asynchronous pins and synchronised copy
  input  wire logic [`SYNC_W-1:0] pins_i,
  output logic      [`SYNC_W-1:0] sync_o
);

  rcw_pkg::sync_state_t s;
  rcw_pkg::sync_state_t next_s;

  // Only the second stage reads the first
  always_comb begin
    next_s      = s;
    next_s.meta = pins_i;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.sync;

endmodule // pin_sync

// ===== src/config_word_latch.sv
// Hard-reset configuration word latch with Wishbone config registers
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "rcw_consts.svh"

module config_word_latch (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Reset-time pins
  input  wire logic        hard_reset_in_n_i,
  input  wire logic        config_source_select_n_i,
  input  wire logic [31:0] ext_data_i,
  // Flash configuration side
  input  wire logic        flash_word_disable_i,
  input  wire logic [31:0] flash_config_word_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Configuration outputs
  output logic             external_arbitration_sel_o,
  output logic             interrupt_prefix_init_o,
  output logic             bus_drive_reduce_o,
  output logic      [1:0]  clock_output_pin_mode_field_o,
  output logic             boot_match_all_o,
  output logic             bank0_enable_o,
  output logic      [31:0] bank0_option_reg_o,
  output logic             bank0_option_written_o,
  output logic             config_valid_o
);

  function automatic logic cfg_bit(input logic [31:0] w, input int n);
    cfg_bit = w[31-n];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic rcw_pkg::sys_cfg_t cfg_defaults(input logic [31:0] w);
    rcw_pkg::sys_cfg_t c;
    c.external_arbitration_sel = cfg_bit(w, `CFG_ARB_BIT);
    c.bus_drive_reduce         = cfg_bit(w, `CFG_DRIVE_BIT);
    c.clock_output_pin_mode = cfg_bit(w, `CFG_DRIVE_BIT) ? `CLOCK_OUTPUT_PIN_MODE_REDUCED
                                               : `CLOCK_OUTPUT_PIN_MODE_FULL;
    cfg_defaults = c;
  endfunction

  localparam rcw_pkg::latch_state_t RESET_ST = '{
    phase: rcw_pkg::ST_HOLD, hr_prev: 1'b0, word: 32'h00000000,
    interrupt_prefix: 1'b0, syscfg: '0, bank0_opt: `BANK0_OPT_RST,
    bank0_written: 1'b0, ack: 1'b0, dat: 32'h00000000};

  logic [`SYNC_W-1:0]   pins_sync;
  logic                 hr_sync;
  logic                 src_sel_n;
  logic [31:0]          ext_sync;
  logic [31:0]          int_bus;
  logic                 release_edge;
  logic                 req;
  logic [5:0]           word_idx;
  logic [31:0]          syscfg_rd;
  logic [31:0]          syscfg_wr;
  rcw_pkg::latch_state_t s;
  rcw_pkg::latch_state_t next_s;

  // Pins are sampled together so the word lines up with the release edge
  pin_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pins_i ({hard_reset_in_n_i, config_source_select_n_i, ext_data_i}),
    .sync_o (pins_sync)
  );

  assign hr_sync      = pins_sync[33];
  assign src_sel_n    = pins_sync[32];
  assign ext_sync     = pins_sync[31:0];
  assign release_edge = hr_sync & ~s.hr_prev;

  // Flash words are only used when enabled; disabled gives zeros
  always_comb begin
    if (!src_sel_n) begin
      int_bus = ext_sync;
    end else if (flash_word_disable_i) begin
      int_bus = 32'h00000000;
    end else begin
      int_bus = flash_config_word_i;
    end
  end

  assign req       = wb_cyc_i & wb_stb_i & ~s.ack;
  assign word_idx  = wb_adr_i[7:2];
  assign syscfg_rd = {28'h0000000, s.syscfg.clock_output_pin_mode,
                      s.syscfg.bus_drive_reduce,
                      s.syscfg.external_arbitration_sel};
  assign syscfg_wr = merge(syscfg_rd, wb_dat_i, wb_sel_i);

  always_comb begin
    next_s         = s;
    next_s.hr_prev = hr_sync;
    next_s.ack     = req;
    if (req && !wb_we_i) begin
      // The captured word itself has no address
      case (word_idx)
        `REG_SYSCFG_IDX: next_s.dat = syscfg_rd;
        `REG_BANK0_IDX:  next_s.dat = s.bank0_opt;
        `REG_STATUS_IDX: next_s.dat = {29'h0, boot_match_all_o,
                                       s.bank0_written,
                                       s.phase == rcw_pkg::ST_RUN};
        default:         next_s.dat = 32'h00000000;
      endcase
    end
    case (s.phase)
      rcw_pkg::ST_HOLD: begin
        next_s.word             = 32'h00000000;
        next_s.interrupt_prefix = 1'b0;
        next_s.syscfg           = cfg_defaults(32'h00000000);
        next_s.bank0_opt        = `BANK0_OPT_RST;
        next_s.bank0_written    = 1'b0;
        if (release_edge) begin
          next_s.phase            = rcw_pkg::ST_RUN;
          next_s.word             = int_bus;
          next_s.syscfg           = cfg_defaults(int_bus);
          next_s.interrupt_prefix = cfg_bit(int_bus, `CFG_PREFIX_BIT);
        end
      end
      rcw_pkg::ST_RUN: begin
        if (!hr_sync) begin
          next_s.phase = rcw_pkg::ST_HOLD;
        end else if (req && wb_we_i) begin
          case (word_idx)
            `REG_SYSCFG_IDX: begin
              next_s.syscfg.external_arbitration_sel =
                syscfg_wr[`SYSCFG_ARB_POS];
              next_s.syscfg.bus_drive_reduce = syscfg_wr[`SYSCFG_DRIVE_POS];
              next_s.syscfg.clock_output_pin_mode =
                syscfg_wr[`SYSCFG_CLOCK_OUTPUT_PIN_LSB +: 2];
            end
            `REG_BANK0_IDX: begin
              next_s.bank0_opt     = merge(s.bank0_opt, wb_dat_i, wb_sel_i);
              next_s.bank0_written = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_s.phase = rcw_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= RESET_ST;
    end else begin
      s <= next_s;
    end
  end

  // Bank 0 enable bit of the option register is taken as its lowest bit
  assign boot_match_all_o = (s.phase == rcw_pkg::ST_RUN) &
                            ~cfg_bit(s.word, `CFG_BOOT_BIT) &
                            ~s.bank0_written;
  assign bank0_enable_o = s.bank0_written ? s.bank0_opt[0]
                                          : boot_match_all_o;

  assign wb_dat_o                   = s.dat;
  assign wb_ack_o                   = s.ack;
  assign external_arbitration_sel_o = s.syscfg.external_arbitration_sel;
  assign interrupt_prefix_init_o    = s.interrupt_prefix;
  assign bus_drive_reduce_o         = s.syscfg.bus_drive_reduce;
  assign clock_output_pin_mode_field_o        = s.syscfg.clock_output_pin_mode;
  assign bank0_option_reg_o         = s.bank0_opt;
  assign bank0_option_written_o     = s.bank0_written;
  assign config_valid_o             = s.phase == rcw_pkg::ST_RUN;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_word_capture: assert property (
    (s.phase == rcw_pkg::ST_HOLD) && release_edge
      |=> (s.word == $past(int_bus)) && config_valid_o)
    else $error("word not captured at hard reset release");

  a_ext_mirror: assert property (
    (s.phase == rcw_pkg::ST_HOLD) && release_edge && !src_sel_n
      |=> s.word == $past(ext_sync))
    else $error("external bus not mirrored into word");

  a_zero_fill: assert property (
    (s.phase == rcw_pkg::ST_HOLD) && release_edge && src_sel_n
      && flash_word_disable_i |=> s.word == 32'h00000000)
    else $error("internal zero word not used");

  a_word_hidden: assert property (
    req && !wb_we_i && (word_idx > `REG_STATUS_IDX)
      |=> wb_ack_o && (wb_dat_o == 32'h00000000))
    else $error("unmapped read did not return zero");

  a_arb_select: assert property (
    (s.phase == rcw_pkg::ST_HOLD) && release_edge
      |=> external_arbitration_sel_o == $past(int_bus[31]))
    else $error("arbitration select not taken from bit 0");

  a_prefix_init: assert property (
    (s.phase == rcw_pkg::ST_HOLD) && release_edge
      |=> interrupt_prefix_init_o == $past(int_bus[30]))
    else $error("interrupt prefix not taken from bit 1");

  a_drive_init: assert property (
    (s.phase == rcw_pkg::ST_HOLD) && release_edge
      |=> (bus_drive_reduce_o == $past(int_bus[29]))
       && (clock_output_pin_mode_field_o == {1'b0, $past(int_bus[29])}))
    else $error("drive strength defaults wrong");

  a_boot_decode: assert property (
    config_valid_o && !bank0_option_written_o
      |-> boot_match_all_o == !s.word[28])
    else $error("boot bank decode wrong");

  a_bank0_override: assert property (
    config_valid_o && req && wb_we_i && (word_idx == `REG_BANK0_IDX)
      && hr_sync |=> !boot_match_all_o && bank0_option_written_o
      && (bank0_enable_o == bank0_option_reg_o[0]))
    else $error("bank 0 write did not override boot setting");

  a_word_held: assert property (
    config_valid_o && hr_sync |=> $stable(s.word)
      && $stable(interrupt_prefix_init_o))
    else $error("captured word changed without hard reset");

endmodule // config_word_latch

// ===== tb/ext_bus_model.sv
// Outside party driving the external data bus around hard reset release
`timescale 1ns/1ns

module ext_bus_model #(
  parameter int HOLD_CYC = 6
) (
  // Clock and observed reset pin
  input  wire logic        clk_i,
  input  wire logic        hard_reset_in_n_i,
  // Word to present and the bus
  input  wire logic [31:0] word_i,
  output logic      [31:0] ext_data_o
);
  int cnt;

  always_ff @(posedge clk_i) begin
    if (!hard_reset_in_n_i) begin
      cnt <= 0;
    end else if (cnt < HOLD_CYC) begin
      cnt <= cnt + 1;
    end
  end

  // Released bus shows the inverse, so a late sample cannot pass
  assign ext_data_o = (cnt < HOLD_CYC) ? word_i : ~word_i;
endmodule // ext_bus_model

// ===== tb/config_word_latch_tb.sv
// Self-checking bench for the configuration word latch
`timescale 1ns/1ns

module config_word_latch_tb;
  logic        clk = 0;
  logic        rst = 1;
  logic        hr_n = 0;
  logic        src_n = 0;
  logic        dis = 1;
  logic [31:0] word = 0;
  logic [31:0] ext;
  logic        req = 0;
  logic        we = 0;
  logic [31:0] adr = 0;
  logic [31:0] wdat = 0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        arb, pfx, drv, bm, b0en, b0wr, vld;
  logic [1:0]  clkm;
  logic [31:0] b0opt;
  logic [8:0]  outs;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;

  assign outs = {arb, pfx, drv, clkm, bm, b0en, b0wr, vld};

  config_word_latch dut (
    .clk_i(clk), .rst_i(rst),
    .hard_reset_in_n_i(hr_n), .config_source_select_n_i(src_n),
    .ext_data_i(ext), .flash_word_disable_i(dis),
    .flash_config_word_i(~word),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_arbitration_sel_o(arb), .interrupt_prefix_init_o(pfx),
    .bus_drive_reduce_o(drv), .clock_output_pin_mode_field_o(clkm),
    .boot_match_all_o(bm), .bank0_enable_o(b0en),
    .bank0_option_reg_o(b0opt), .bank0_option_written_o(b0wr),
    .config_valid_o(vld)
  );

  ext_bus_model bus (
    .clk_i(clk), .hard_reset_in_n_i(hr_n), .word_i(word), .ext_data_o(ext)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [8:0] exp_outs(input logic [3:0] p);
    return {p[0], p[1], p[2], 1'b0, p[2], ~p[3], ~p[3], 2'b01};
  endfunction

  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    req <= 1'b0;
    we <= 1'b0;
    chk({31'h0, ack}, 32'h1);
  endtask

  task automatic capture(input logic s, input logic [31:0] w);
    @(posedge clk);
    hr_n <= 1'b0;
    src_n <= s;
    word <= w;
    repeat (6) @(posedge clk);
    hr_n <= 1'b1;
    for (int n = 0; n < 20 && vld !== 1'b1; n++) @(posedge clk);
    @(posedge clk);
    chk({31'h0, vld}, 32'h1);
  endtask

  task automatic test_ext_capture;
    logic [3:0] p;
    for (int i = 0; i < 16; i++) begin
      p = i[3:0];
      capture(1'b0, {p[0], p[1], p[2], p[3], 28'hA5A5A5A});
      chk(outs, exp_outs(p));
      wb(1'b0, 32'h0, 32'h0);
      chk(q, {28'h0, 1'b0, p[2], p[2], p[0]});
      wb(1'b0, 32'h8, 32'h0);
      chk(q, {29'h0, ~p[3], 2'b01});
    end
    wb(1'b0, 32'hC, 32'h0);
    chk(q, 32'h0);
  endtask

  // Internal source: zeros when flash words are off, flash word otherwise
  task automatic test_zero_word;
    dis <= 1'b1;
    capture(1'b1, 32'hF0000000);
    chk(outs, exp_outs(4'h0));
    dis <= 1'b0;
    capture(1'b1, 32'h0FFFFFFF);
    chk(outs, exp_outs(4'hF));
    dis <= 1'b1;
  endtask

  task automatic test_bank0_write;
    capture(1'b0, 32'h0AAAAAAA);
    wb(1'b1, 32'h4, 32'hABCD1230);
    chk({b0en, b0wr}, 2'b01);
    chk(b0opt, 32'hABCD1230);
    wb(1'b0, 32'h4, 32'h0);
    chk(q, 32'hABCD1230);
    capture(1'b0, 32'h1AAAAAAA);
    chk({b0en, bm, b0wr}, 3'b000);
    wb(1'b1, 32'h4, 32'h00000001);
    chk({b0en, b0wr}, 2'b11);
  endtask

  task automatic test_hold_and_rewrite;
    capture(1'b0, 32'h7AAAAAAA);
    repeat (20) @(posedge clk);
    chk(outs, exp_outs(4'hE));
    wb(1'b1, 32'h0, 32'h00000009);
    chk({arb, drv, clkm, pfx}, 5'b10101);
    @(posedge clk);
    hr_n <= 1'b0;
    repeat (5) @(posedge clk);
    // Writes during hard reset are acked but must leave no trace
    wb(1'b1, 32'h4, 32'h00000005);
    chk(outs, 32'h0);
    capture(1'b0, 32'h0AAAAAAA);
    chk(outs, exp_outs(4'h0));
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_ext_capture();
    test_zero_word();
    test_bank0_write();
    test_hold_and_rewrite();
    tally_and_finish();
  end
endmodule // config_word_latch_tb
